// ===== src/fspc_pkg.sv
package fspc_pkg;
   // apb byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] Z_OFF      = 8'h04;
   localparam logic [7:0] DATA_OFF   = 8'h08;
   localparam logic [7:0] INSTR_OFF  = 8'h0C;
   localparam logic [7:0] RDATA_OFF  = 8'h10;
   localparam logic [7:0] LOCK_OFF   = 8'h14;
   localparam logic [7:0] STAT_OFF   = 8'h18;
   localparam logic [7:0] BUF_OFF    = 8'h80;
   // control bit positions
   localparam int IE_BIT   = 7;
   localparam int BUSY_BIT = 6;
   localparam int SRE_BIT  = 4;
   localparam int LSEL_BIT = 3;
   localparam int PGW_BIT  = 2;
   localparam int PGE_BIT  = 1;
   localparam int SPE_BIT  = 0;
   // low five command patterns
   localparam logic [4:0] CMD_LOCK   = 5'h09;
   localparam logic [4:0] CMD_PGWR   = 5'h05;
   localparam logic [4:0] CMD_PGER   = 5'h03;
   localparam logic [4:0] CMD_SRE    = 5'h11;
   localparam logic [4:0] CMD_LOAD   = 5'h01;
   // z pointer fields
   localparam int PAGE_HI = 13;
   localparam int PAGE_LO = 7;
   localparam int WORD_HI = 6;
   localparam int WORD_LO = 1;
   // instruction windows in cycles
   localparam logic [2:0] STORE_WIN = 3'h4;
   localparam logic [2:0] LOAD_WIN  = 3'h3;
   // z values for readback
   localparam logic [15:0] Z_LFUSE = 16'h0000;
   localparam logic [15:0] Z_LOCK  = 16'h0001;
   localparam logic [15:0] Z_EFUSE = 16'h0002;
   localparam logic [15:0] Z_HFUSE = 16'h0003;
   localparam logic [7:0]  EFUSE_MASK = 8'h1E;
   localparam logic [7:0]  LOCK_RESET = 8'hFF;
   // instruction trigger codes
   localparam logic [1:0] INSTR_STORE = 2'h1;
   localparam logic [1:0] INSTR_LOAD  = 2'h2;
   // programming time
   localparam int PROG_TIME_US = 4000;
   localparam int CLK_MHZ      = 250;
   localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
   typedef enum logic [1:0] {
      FSPC_IDLE  = 2'b00,
      FSPC_PAGE  = 2'b01,
      FSPC_LOCKW = 2'b10
   } fspc_state_t;
endpackage : fspc_pkg

// ===== src/fspc_top.sv
`timescale 1ns/1ps
module fspc_top
   import fspc_pkg::*;
#(
   parameter int          WORDS       = 64,
   parameter int          NO_READ_WHILE_WRITE_SECTION_PAGE   = 112,
   parameter int          PROG_CNT    = PROG_CYCLES,
   parameter logic [7:0]  LOW_FUSE    = 8'hFF,
   parameter logic [7:0]  HIGH_FUSE   = 8'hFF,
   parameter logic [7:0]  EXT_FUSE    = 8'hFF,
   parameter logic [1:0]  MEM_LOCK    = 2'h3
) (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        clk_en_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic [31:0]      prdata_out,
   output logic             pslverr_out,
   input  wire logic        eeprom_write_busy_in,
   input  wire logic [7:0]  flash_byte_in,
   output logic             irq_out,
   output logic             cpu_halt_out,
   output logic             rww_block_out,
   output logic             page_write_out,
   output logic [6:0]       page_number_out
);
   localparam int WB = $clog2(WORDS);

   logic        rst_s1_reg;
   logic        rst_n_reg;
   logic        ee_s1_reg;
   logic        ee_reg;
   logic [7:0]  ctrl_reg;
   logic [15:0] z_reg;
   logic [15:0] data_reg;
   logic [7:0]  rd_reg;
   logic [5:2]  lock_reg;
   logic [2:0]  win_reg;
   logic [31:0] prog_reg;
   logic [6:0]  page_reg;
   fspc_state_t state_reg;
   logic [15:0] buf_reg [WORDS];
   logic        page_wr_reg;
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic        irq_reg;
   logic        halt_reg;
   logic        busy_out_reg;

   // reset release through two stages
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg  <= rst_s1_reg;
      end
   end

   // eeprom busy comes from another block, synchronise it
   always_ff @(posedge clock_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ee_s1_reg <= 1'b0;
         ee_reg    <= 1'b0;
      end else if (clk_en_in) begin
         ee_s1_reg <= eeprom_write_busy_in;
         ee_reg    <= ee_s1_reg;
      end
   end

   // apb decode, one named hit per register
   wire         acc      = psel_in && penable_in && !pready_reg;
   wire         wr       = acc && pwrite_in;
   wire         rd       = acc && !pwrite_in;
   wire         hit_ctrl = paddr_in == CTRL_OFF;
   wire         hit_z    = paddr_in == Z_OFF;
   wire         hit_data = paddr_in == DATA_OFF;
   wire         hit_ins  = paddr_in == INSTR_OFF;
   wire         hit_rdat = paddr_in == RDATA_OFF;
   wire         hit_lock = paddr_in == LOCK_OFF;
   wire         hit_stat = paddr_in == STAT_OFF;
   wire         buf_hit  = paddr_in >= BUF_OFF;
   wire [WB-1:0] buf_idx = WB'(paddr_in[7:2] - BUF_OFF[7:2]);
   wire         known    = buf_hit || hit_ctrl || hit_z || hit_data ||
                           hit_ins || hit_rdat || hit_lock || hit_stat;
   wire         buf_ok   = buf_hit && int'(buf_idx) < WORDS;
   wire         unmapped = !known || (buf_hit && !buf_ok);

   // control write: only the five patterns, never while busy or eeprom
   wire         ctrl_wr  = wr && hit_ctrl;
   wire [4:0]   cmd_in   = pwdata_in[4:0];
   wire         cmd_ok   = cmd_in == CMD_LOCK || cmd_in == CMD_PGWR ||
                           cmd_in == CMD_PGER || cmd_in == CMD_SRE ||
                           cmd_in == CMD_LOAD;
   wire         idle     = state_reg == FSPC_IDLE;
   wire         arm      = ctrl_wr && cmd_ok && idle && !ee_reg;
   wire         armed    = ctrl_reg[SPE_BIT] && idle && win_reg != 3'h0;

   // instruction triggers from the core
   wire         instr_wr = wr && hit_ins;
   wire         do_store = instr_wr && pwdata_in[1:0] == INSTR_STORE && armed
                           && !ee_reg;
   wire         do_load  = instr_wr && pwdata_in[1:0] == INSTR_LOAD;
   wire         rb_armed = armed && ctrl_reg[LSEL_BIT] &&
                           win_reg > (STORE_WIN - LOAD_WIN);
   wire         do_rb    = do_load && rb_armed && !ee_reg;
   wire [4:0]   cur_cmd  = ctrl_reg[4:0];
   wire         st_load  = do_store && cur_cmd == CMD_LOAD;
   wire         st_pgwr  = do_store && cur_cmd == CMD_PGWR;
   wire         st_lock  = do_store && cur_cmd == CMD_LOCK;
   wire         st_sre   = do_store && cur_cmd == CMD_SRE;
   wire [6:0]   z_page   = z_reg[PAGE_HI:PAGE_LO];
   wire [WB-1:0] z_word  = WB'(z_reg[WORD_HI:WORD_LO]);
   wire         prog_end = !idle && prog_reg == 32'h1;
   wire         clr_buf  = (prog_end && state_reg == FSPC_PAGE) || st_sre;
   wire         halt_set = st_pgwr && int'(z_page) >= NO_READ_WHILE_WRITE_SECTION_PAGE;

   // window events; arming always wins over a clear
   wire         win_done = do_rb || do_store;
   wire         win_exp  = idle && win_reg == 3'h1;
   wire         cmd_done = do_rb || (do_store && (st_load || st_sre));
   wire         cmd_clr  = cmd_done || prog_end || win_exp;

   // readback selection, fuses are active-low in storage already
   wire [7:0]   lock_byte = {2'b11, lock_reg[5:2], MEM_LOCK};
   wire [7:0]   rb_byte   =
      (z_reg == Z_LOCK)  ? lock_byte :
      (z_reg == Z_LFUSE) ? LOW_FUSE :
      (z_reg == Z_HFUSE) ? HIGH_FUSE :
      (z_reg == Z_EFUSE) ? (EXT_FUSE | ~EFUSE_MASK) :
      8'hFF;
   wire [7:0]   load_byte = do_rb ? rb_byte : flash_byte_in;

   wire [31:0]  rd_mux =
      buf_ok                  ? {16'h0000, buf_reg[buf_idx]} :
      hit_ctrl                ? {24'h0, ctrl_reg} :
      hit_z                   ? {16'h0, z_reg} :
      hit_data                ? {16'h0, data_reg} :
      hit_rdat                ? {24'h0, rd_reg} :
      hit_lock                ? {24'h0, lock_byte} :
      hit_stat                ? {29'h0, busy_out_reg, halt_reg, ee_reg} :
      32'h0;

   // apb answer one cycle after the access phase opens
   always_ff @(posedge clock_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (clk_en_in) begin
         pready_reg  <= acc;
         pslverr_reg <= acc && unmapped;
         prdata_reg  <= rd ? rd_mux : 32'h0;
      end
   end

   // core-side data registers
   always_ff @(posedge clock_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         z_reg    <= 16'h0;
         data_reg <= 16'h0;
         rd_reg   <= 8'h0;
      end else if (clk_en_in) begin
         if (wr && hit_z) begin
            z_reg <= pwdata_in[15:0];
         end
         if (wr && hit_data) begin
            data_reg <= pwdata_in[15:0];
         end
         if (do_load) begin
            rd_reg <= load_byte;
         end
      end
   end

   // control register; enable stays up while the flash is busy
   always_ff @(posedge clock_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ctrl_reg <= 8'h0;
      end else if (clk_en_in) begin
         if (ctrl_wr) begin
            ctrl_reg[IE_BIT] <= pwdata_in[IE_BIT];
         end
         if (arm) begin
            ctrl_reg[4:0] <= cmd_in;
         end else if (cmd_clr) begin
            ctrl_reg[4:0] <= 5'h00;
         end
      end
   end

   // window counter, loaded on arming, stopped by the instruction
   always_ff @(posedge clock_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         win_reg <= 3'h0;
      end else if (clk_en_in) begin
         if (arm) begin
            win_reg <= STORE_WIN;
         end else if (win_done || win_exp) begin
            win_reg <= 3'h0;
         end else if (win_reg != 3'h0) begin
            win_reg <= win_reg - 3'h1;
         end
      end
   end

   // busy flag: set on any page write, cleared by reenable or buffer load
   always_ff @(posedge clock_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         busy_out_reg <= 1'b0;
      end else if (clk_en_in) begin
         // any page write blocks the section, not only its own pages
         if (st_pgwr) begin
            busy_out_reg <= 1'b1;
         end else if ((st_sre || st_load) && idle) begin
            busy_out_reg <= 1'b0;
         end
      end
   end

   // programming sequencer; no reset at all, not even the raw pin,
   // so the operation itself is never aborted
   always_ff @(posedge clock_in) begin
      if (clk_en_in) begin
         case (state_reg)
            FSPC_IDLE: begin
               page_wr_reg <= st_pgwr;
               halt_reg    <= halt_set;
               if (st_pgwr) begin
                  state_reg <= FSPC_PAGE;
                  page_reg  <= z_page;
                  prog_reg  <= 32'(PROG_CNT);
               end else if (st_lock) begin
                  state_reg <= FSPC_LOCKW;
                  prog_reg  <= 32'(PROG_CNT);
               end
            end
            FSPC_PAGE, FSPC_LOCKW: begin
               if (prog_end) begin
                  state_reg <= FSPC_IDLE;
               end
               prog_reg    <= prog_reg - 32'h1;
               page_wr_reg <= state_reg == FSPC_PAGE && !prog_end;
               halt_reg    <= halt_reg && !prog_end;
            end
            default: begin
               state_reg   <= FSPC_IDLE;
               page_wr_reg <= 1'b0;
               halt_reg    <= 1'b0;
            end
         endcase
      end
   end

   // lock bits: a zero in r0 programs, a one leaves the bit alone
   genvar gl;
   for (gl = 2; gl <= 5; gl++) begin : g_lock
      always_ff @(posedge clock_in or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            lock_reg[gl] <= LOCK_RESET[gl];
         end else if (clk_en_in && st_lock && !data_reg[gl]) begin
            lock_reg[gl] <= 1'b0;
         end
      end
   end

   // temporary page buffer
   genvar gi;
   for (gi = 0; gi < WORDS; gi++) begin : g_buf
      always_ff @(posedge clock_in or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            buf_reg[gi] <= 16'hFFFF;
         end else if (clk_en_in) begin
            if (clr_buf) begin
               buf_reg[gi] <= 16'hFFFF;
            end else if (st_load && z_word == WB'(gi)) begin
               buf_reg[gi] <= data_reg;
            end
         end
      end
   end

   // ready interrupt; halt lives with the sequencer so reset spares it
   always_ff @(posedge clock_in or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         irq_reg <= 1'b0;
      end else if (clk_en_in) begin
         irq_reg <= ctrl_reg[IE_BIT] && !ctrl_reg[SPE_BIT];
      end
   end

   assign pready_out      = pready_reg;
   assign prdata_out      = prdata_reg;
   assign pslverr_out     = pslverr_reg;
   assign irq_out         = irq_reg;
   assign cpu_halt_out    = halt_reg;
   // lock programming never blocks reads
   assign rww_block_out   = busy_out_reg;
   assign page_write_out  = page_wr_reg;
   assign page_number_out = page_reg;
endmodule : fspc_top

// ===== tb/fspc_top_asserts.sv
`timescale 1ns/1ps
module fspc_top_asserts #(
   parameter int NO_READ_WHILE_WRITE_SECTION_PAGE = 112
) (
   input wire logic       clock_in,
   input wire logic       resetn_in,
   input wire logic       psel_in,
   input wire logic       penable_in,
   input wire logic       pwrite_in,
   input wire logic       pready_out,
   input wire logic       pslverr_out,
   input wire logic       irq_out,
   input wire logic       cpu_halt_out,
   input wire logic       rww_block_out,
   input wire logic       page_write_out,
   input wire logic [6:0] page_number_out
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!resetn_in);

   // apb answer shape
   pready_pulse_a: assert property (pready_out |=> !pready_out)
      else $error("pready held longer than one cycle");
   pready_cause_a: assert property ($rose(pready_out)
      |-> $past(psel_in && penable_in))
      else $error("pready without an access phase");
   slverr_ready_a: assert property (pslverr_out |-> pready_out)
      else $error("slave error outside the answer cycle");
   // section busy and halt during a page write
   busy_on_write_a: assert property ($rose(page_write_out)
      |-> ##[0:1] rww_block_out)
      else $error("section not busy at page write start");
   busy_clear_a: assert property ($fell(rww_block_out)
      |-> $past(psel_in && penable_in && pwrite_in))
      else $error("section busy flag dropped without a write");
   halt_no_read_while_write_section_a: assert property (cpu_halt_out
      |-> page_number_out >= NO_READ_WHILE_WRITE_SECTION_PAGE)
      else $error("cpu halted for a read-while-write page");
   no_halt_rww_a: assert property ($rose(page_write_out)
      && page_number_out < NO_READ_WHILE_WRITE_SECTION_PAGE |=> !cpu_halt_out)
      else $error("cpu halted while writing a readable section");
   write_len_a: assert property ($rose(page_write_out)
      |-> page_write_out[*8])
      else $error("page write ended too early");
   page_hold_a: assert property (page_write_out && $past(page_write_out)
      |-> $stable(page_number_out))
      else $error("page number moved during a write");
   irq_quiet_a: assert property (page_write_out |-> !irq_out)
      else $error("ready interrupt while programming");
   cover property ($rose(page_write_out));
   cover property ($rose(cpu_halt_out));
   cover property (pslverr_out);
endmodule : fspc_top_asserts

bind fspc_top fspc_top_asserts #(.NO_READ_WHILE_WRITE_SECTION_PAGE(NO_READ_WHILE_WRITE_SECTION_PAGE)) u_chk (
   .clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
   .cpu_halt_out(cpu_halt_out), .rww_block_out(rww_block_out),
   .page_write_out(page_write_out), .page_number_out(page_number_out));

// ===== tb/fspc_cpu.sv
`timescale 1ns/1ps
module fspc_cpu
   import fspc_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        pready_in,
   input  wire logic        ebusy_in,
   output logic             psel_out,
   output logic             penable_out,
   output logic             pwrite_out,
   output logic [7:0]       paddr_out,
   output logic [31:0]      pwdata_out
);
   initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;

   // one apb transfer, request held until pready is seen
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
      psel_out    <= 1'b1;
      pwrite_out  <= wr;
      paddr_out   <= a;
      pwdata_out  <= d;
      @(posedge clock_in);
      penable_out <= 1'b1;
      do @(posedge clock_in); while (pready_in !== 1'b1);
      penable_out <= 1'b0;
   endtask : xfer

   // bus released for one cycle
   task automatic idle();
      psel_out    <= 1'b0;
      penable_out <= 1'b0;
      @(posedge clock_in);
   endtask : idle

   // timed pair: the instruction must be the very next transfer
   task automatic spm(input logic [7:0] c, input logic [1:0] ins,
                      input logic chk);
      while (chk && ebusy_in === 1'b1) idle();
      xfer(1'b1, CTRL_OFF, {24'h0, c});
      xfer(1'b1, INSTR_OFF, {30'h0, ins});
   endtask : spm
endmodule : fspc_cpu

// ===== tb/tb.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin \
   error_cnt++; $display("Error at %0t: %s", $time, m); end end
module tb
   import fspc_pkg::*;
;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} fspc_exp_t;
   logic clock_in = 0, resetn_in = 0, clk_en_in = 1, ebusy = 0;
   logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic irq_out, cpu_halt_out, rww_block_out, page_write_out;
   logic [7:0]  paddr_in, flash_byte_in = 8'h00;
   logic [31:0] pwdata_in, prdata_out;
   logic [6:0]  page_number_out;
   logic [15:0] seed = 16'h0033;
   logic [4:0]  n;
   fspc_exp_t   exp_q[$], e;
   int          error_cnt = 0, n_checks = 0, j;
   localparam logic [7:0] FZ[4] = '{8'hA5, {4'hF, 4'hE}, 8'hF9, 8'h3C};
   localparam logic [7:0] FM[4] = '{8'hFF, 8'h3F, 8'h1E, 8'hFF};

   always #2 clock_in = ~clock_in;

   fspc_top #(.PROG_CNT(20), .LOW_FUSE(8'hA5), .HIGH_FUSE(8'h3C),
      .EXT_FUSE(8'hF9), .MEM_LOCK(2'h2)) DUT (
      .clock_in(clock_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
      .prdata_out(prdata_out), .pslverr_out(pslverr_out),
      .eeprom_write_busy_in(ebusy), .flash_byte_in(flash_byte_in),
      .irq_out(irq_out), .cpu_halt_out(cpu_halt_out),
      .rww_block_out(rww_block_out), .page_write_out(page_write_out),
      .page_number_out(page_number_out));
   fspc_cpu cpu (.clock_in(clock_in), .pready_in(pready_out),
      .ebusy_in(ebusy), .psel_out(psel_in), .penable_out(penable_in),
      .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d);
   endtask : wr
   // expectation is queued before the read is issued
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic se);
      exp_q.push_back('{d, m, se});
      cpu.xfer(1'b0, a, 32'h0);
   endtask : rd
   task automatic complete_run();
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // read answers are matched oldest first
   always @(posedge clock_in) begin
      if (pready_out === 1'b1 && pwrite_in === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK(prdata_out & e.m, e.d & e.m, "read data")
         `CHK(pslverr_out, e.e, "slave error flag")
      end
   end

   // long enough for every page write plus margin
   initial begin
      repeat (20000) @(posedge clock_in);
      error_cnt++;
      complete_run();
   end

   initial begin
      repeat (6) @(posedge clock_in);
      resetn_in <= 1'b1;
      seed = lfsr(seed);
      flash_byte_in <= seed[7:0];
      repeat (4) @(posedge clock_in);
      rd(CTRL_OFF, 32'h0, 32'hFF, 1'b0);
      rd(LOCK_OFF, 32'h3C, 32'h3C, 1'b0);
      rd(8'h40, 32'h0, 32'h0, 1'b1);
      for (j = 0; j < 4; j++) begin
         wr(Z_OFF, j);
         cpu.spm(8'h09, INSTR_LOAD, 1'b1);
         rd(RDATA_OFF, FZ[j], FM[j], 1'b0); // 21
         rd(CTRL_OFF, 32'h0, 32'h09, 1'b0);
      end
      wr(INSTR_OFF, INSTR_LOAD);
      rd(RDATA_OFF, {24'h0, flash_byte_in}, 32'hFF, 1'b0);
      wr(CTRL_OFF, 8'h09);
      repeat (6) cpu.idle();
      rd(CTRL_OFF, 32'h0, 32'h1F, 1'b0);
      wr(CTRL_OFF, 8'h07);
      rd(CTRL_OFF, 32'h0, 32'h1F, 1'b0);
      wr(CTRL_OFF, 8'h80);
      cpu.idle();
      `CHK(irq_out, 1'b1, "ready interrupt")
      wr(CTRL_OFF, 8'h00);
      for (j = 0; j < 4; j++) begin
         seed = lfsr(seed);
         n = 5'(j * 8) + 5'(seed[2:0]); // each word once only
         wr(Z_OFF, {26'h0, n, 1'b0});
         wr(DATA_OFF, {16'h0, seed});
         cpu.spm(8'h01, INSTR_STORE, 1'b1);
         rd(BUF_OFF + 8'(n * 4), {16'h0, seed}, 32'hFFFF, 1'b0);
      end
      for (j = 0; j < 3; j++) begin
         wr(Z_OFF, (j == 0 ? 5 : 120) << 7);
         cpu.spm(8'h05, INSTR_STORE, 1'b1);
         repeat (2) cpu.idle();
         if (j == 2) begin
            resetn_in <= 1'b0;
            cpu.idle();
            resetn_in <= 1'b1;
            repeat (4) cpu.idle();
         end
         `CHK(page_write_out, 1'b1, "page write running")
         `CHK(cpu_halt_out, j > 0, "cpu halt")
         `CHK(page_number_out, 7'(j == 0 ? 5 : 120), "page")
         for (int k = 0; k < 60 && page_write_out === 1'b1; k++) cpu.idle();
         `CHK(page_write_out, 1'b0, "page write done")
         if (j < 2) `CHK(rww_block_out, 1'b1, "section busy")
         rd(BUF_OFF + 8'(n * 4), 32'hFFFF, 32'hFFFF, 1'b0);
         cpu.spm(8'h11, INSTR_STORE, 1'b1);
         cpu.idle();
         `CHK(rww_block_out, 1'b0, "section reenabled")
      end
      wr(DATA_OFF, 32'hDB); // unused bits one
      wr(Z_OFF, 32'h1);
      cpu.spm(8'h09, INSTR_STORE, 1'b1);
      repeat (30) cpu.idle();
      `CHK({cpu_halt_out, rww_block_out}, 2'b00, "lock write")
      rd(LOCK_OFF, 32'h18, 32'h3C, 1'b0);
      ebusy <= 1'b1;
      repeat (4) cpu.idle();
      cpu.spm(8'h09, INSTR_LOAD, 1'b0);
      rd(CTRL_OFF, 32'h0, 32'h1F, 1'b0);
      rd(RDATA_OFF, {24'h0, flash_byte_in}, 32'hFF, 1'b0);
      ebusy <= 1'b0;
      cpu.idle();
      complete_run();
   end
endmodule : tb
